//--- verilog/probe_ctrl_defs.vh
// Constants for the debug probe control and flow trace block
`ifndef PROBE_CTRL_DEFS_VH
`define PROBE_CTRL_DEFS_VH

`define CLK_PERIOD_NS 100
`define TRACE_CLK_HALF_NS 200
`define TRACE_CLK_HALF_CYC 4'h2
`define DIV_ONE 4'h1
`define DIV_ZERO 4'h0

`define PROBE_ADDR_LO 32'hFF20_0000
`define PROBE_ADDR_HI 32'hFF2F_FFFF

`define IR_WIDTH 5
`define IR_BYPASS 5'h1F
`define IR_CAPTURE 5'h01
`define IR_CONTROL 5'h0A
`define IR_TRACE 5'h10

`define CTL_PROBE_PRESENT 15
`define CTL_PENDING 18
`define CTL_WRITE_FLAG 19
`define CTL_PERIPH_RESET 20
`define CTL_RUN 21
`define CTL_SYNC 23
`define CTL_ZERO 32'h0000_0000

`define TRACE_ABSENT 1'b0
`define RUN_RESET 1'b1
`define PC_BITS 6'h20
`define PC_LEFT_ZERO 6'h00
`define PC_LEFT_ONE 6'h01
`define STATUS_IDLE 3'h0

`define TAP_RESET 4'h0
`define TAP_RUN_IDLE 4'h1
`define TAP_SEL_DR 4'h2
`define TAP_CAP_DR 4'h3
`define TAP_SHIFT_DR 4'h4
`define TAP_EXIT1_DR 4'h5
`define TAP_PAUSE_DR 4'h6
`define TAP_EXIT2_DR 4'h7
`define TAP_UPD_DR 4'h8
`define TAP_SEL_IR 4'h9
`define TAP_CAP_IR 4'hA
`define TAP_SHIFT_IR 4'hB
`define TAP_EXIT1_IR 4'hC
`define TAP_PAUSE_IR 4'hD
`define TAP_EXIT2_IR 4'hE
`define TAP_UPD_IR 4'hF

`endif

//--- verilog/tap_walker.v
// Test clock sampler and test access port state machine
`timescale 1ns/100ps
`default_nettype none
`include "probe_ctrl_defs.vh"
module tap_walker (
    input wire clk_i,
    input wire srst_i,
    input wire tck_i,
    input wire tms_i,
    input wire tdi_i,
    output reg tck_rise_o,
    output reg tck_fall_o,
    output reg tdi_o,
    output reg [3:0] state_o
);
    localparam [3:0] S_RESET = `TAP_RESET;
    localparam [3:0] S_IDLE = `TAP_RUN_IDLE;
    localparam [3:0] S_SEL_DR = `TAP_SEL_DR;
    localparam [3:0] S_CAP_DR = `TAP_CAP_DR;
    localparam [3:0] S_SHIFT_DR = `TAP_SHIFT_DR;
    localparam [3:0] S_EXIT1_DR = `TAP_EXIT1_DR;
    localparam [3:0] S_PAUSE_DR = `TAP_PAUSE_DR;
    localparam [3:0] S_EXIT2_DR = `TAP_EXIT2_DR;
    localparam [3:0] S_UPD_DR = `TAP_UPD_DR;
    localparam [3:0] S_SEL_IR = `TAP_SEL_IR;
    localparam [3:0] S_CAP_IR = `TAP_CAP_IR;
    localparam [3:0] S_SHIFT_IR = `TAP_SHIFT_IR;
    localparam [3:0] S_EXIT1_IR = `TAP_EXIT1_IR;
    localparam [3:0] S_PAUSE_IR = `TAP_PAUSE_IR;
    localparam [3:0] S_EXIT2_IR = `TAP_EXIT2_IR;
    localparam [3:0] S_UPD_IR = `TAP_UPD_IR;

    reg tck_s1, tck_s2, tck_s3;
    reg tms_s1, tms_s2;
    reg tdi_s1, tdi_s2;
    reg [3:0] next_state;

    // Pins pass two flops before use; third tck flop finds edges
    always @(posedge clk_i) begin
        if (srst_i) begin
            tck_s1 <= 1'b0;
            tck_s2 <= 1'b0;
            tck_s3 <= 1'b0;
            tms_s1 <= 1'b1;
            tms_s2 <= 1'b1;
            tdi_s1 <= 1'b0;
            tdi_s2 <= 1'b0;
        end else begin
            tck_s1 <= tck_i;
            tck_s2 <= tck_s1;
            tck_s3 <= tck_s2;
            tms_s1 <= tms_i;
            tms_s2 <= tms_s1;
            tdi_s1 <= tdi_i;
            tdi_s2 <= tdi_s1;
        end
    end

    always @* begin
        case (state_o)
            S_RESET: next_state = tms_s2 ? S_RESET : S_IDLE;
            S_IDLE: next_state = tms_s2 ? S_SEL_DR : S_IDLE;
            S_SEL_DR: next_state = tms_s2 ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: next_state = tms_s2 ? S_EXIT1_DR : S_SHIFT_DR;
            S_SHIFT_DR: next_state = tms_s2 ? S_EXIT1_DR : S_SHIFT_DR;
            S_EXIT1_DR: next_state = tms_s2 ? S_UPD_DR : S_PAUSE_DR;
            S_PAUSE_DR: next_state = tms_s2 ? S_EXIT2_DR : S_PAUSE_DR;
            S_EXIT2_DR: next_state = tms_s2 ? S_UPD_DR : S_SHIFT_DR;
            S_UPD_DR: next_state = tms_s2 ? S_SEL_DR : S_IDLE;
            S_SEL_IR: next_state = tms_s2 ? S_RESET : S_CAP_IR;
            S_CAP_IR: next_state = tms_s2 ? S_EXIT1_IR : S_SHIFT_IR;
            S_SHIFT_IR: next_state = tms_s2 ? S_EXIT1_IR : S_SHIFT_IR;
            S_EXIT1_IR: next_state = tms_s2 ? S_UPD_IR : S_PAUSE_IR;
            S_PAUSE_IR: next_state = tms_s2 ? S_EXIT2_IR : S_PAUSE_IR;
            S_EXIT2_IR: next_state = tms_s2 ? S_UPD_IR : S_SHIFT_IR;
            S_UPD_IR: next_state = tms_s2 ? S_SEL_DR : S_IDLE;
            default: next_state = S_RESET;
        endcase
    end

    // State advances just after the rise pulse, so users see the state it hit
    always @(posedge clk_i) begin
        if (srst_i) begin
            state_o <= S_RESET;
            tck_rise_o <= 1'b0;
            tck_fall_o <= 1'b0;
            tdi_o <= 1'b0;
        end else begin
            tck_rise_o <= tck_s2 & ~tck_s3;
            tck_fall_o <= ~tck_s2 & tck_s3;
            tdi_o <= tdi_s2;
            if (tck_rise_o) begin
                state_o <= next_state;
            end
        end
    end
endmodule
`default_nettype wire

//--- verilog/probe_ctrl_trace.v
// Debug probe control register upper half and flow trace mode
//
// Behaviour
// - Processor access to the probe address range sets the pending flag while the probe present bit is set and sync is clear.
// - Write flag reads 1 for a pending write, 0 for a pending read.
// - Peripheral reset request holds all peripherals, not debug logic, in reset.
// - Run bit shows processor clock running at capture; resets to 1.
// - Sync bit stalls the last read's completion until trace mode is active.
// - Sync accepts 1 only with a pending clear ending a read.
// - Sync clears itself when trace mode is entered.
// - Writing 0 to sync clears it and acknowledges the stalled read.
// - Without trace support sync is read-only zero.
// - Trace output length field always reads 00.
// - Bit 22 reads 0 and ignores writes.
// - Trace mode starts once trace instruction is loaded and state is idle.
// - In trace mode the data-out pin emits non-sequential program counters.
// - In trace mode status pins show the execution type code.
// - Debug exception ends trace mode and loads the bypass instruction.
// - Access logic uses bus clock; test controller logic follows test clock.
`timescale 1ns/100ps
`default_nettype none
`include "probe_ctrl_defs.vh"
module probe_ctrl_trace (
    input wire clk_i,
    input wire srst_i,
    input wire tck_i,
    input wire tms_i,
    input wire tdi_i,
    output reg tdo_o,
    output reg tdo_oe_o,
    output reg trace_clk_o,
    output reg [2:0] trace_status_o,
    input wire cpu_req_i,
    input wire [31:0] cpu_addr_i,
    input wire cpu_write_i,
    output reg cpu_ack_o,
    input wire cpu_clk_running_i,
    input wire debug_exc_i,
    input wire pc_valid_i,
    input wire [31:0] pc_i,
    input wire [2:0] pc_status_i,
    output reg periph_reset_o,
    output reg trace_mode_o
);
    wire tck_rise;
    wire tck_fall;
    wire tdi_s;
    wire [3:0] tap_state;

    reg [`IR_WIDTH-1:0] ir;
    reg [`IR_WIDTH-1:0] ir_shift;
    reg [31:0] dr;
    reg [31:0] capture_word;
    reg processor_access_pending;
    reg access_write_flag;
    reg peripheral_reset_request;
    reg probe_present;
    reg sync_hold;
    reg run_state;
    reg flow_trace_mode;
    reg next_trace_mode;
    reg [3:0] div_cnt;
    reg [31:0] pc_shift;
    reg [5:0] pc_left;
    reg trace_bit;

    wire ctl_sel = (ir == `IR_CONTROL);
    wire ctl_update = tck_rise & (tap_state == `TAP_UPD_DR) & ctl_sel;
    wire in_range = (cpu_addr_i >= `PROBE_ADDR_LO) & (cpu_addr_i <= `PROBE_ADDR_HI);
    wire access_set = cpu_req_i & in_range & probe_present & ~processor_access_pending
        & ~sync_hold;
    wire access_clear = ctl_update & ~dr[`CTL_PENDING] & processor_access_pending;
    wire sync_accept = access_clear & ~access_write_flag & dr[`CTL_SYNC] & ~`TRACE_ABSENT;
    wire trace_entry = next_trace_mode & ~flow_trace_mode;
    wire sync_zero = ctl_update & ~dr[`CTL_SYNC] & sync_hold;
    wire div_wrap = (div_cnt == `DIV_ZERO);
    wire trace_fall = probe_present & div_wrap & trace_clk_o;

    tap_walker u_tap (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .tck_i(tck_i),
        .tms_i(tms_i),
        .tdi_i(tdi_i),
        .tck_rise_o(tck_rise),
        .tck_fall_o(tck_fall),
        .tdi_o(tdi_s),
        .state_o(tap_state)
    );

    // Control word seen by the probe; unlisted bits stay zero
    always @* begin
        capture_word = `CTL_ZERO;
        capture_word[`CTL_PROBE_PRESENT] = probe_present;
        capture_word[`CTL_PENDING] = processor_access_pending;
        capture_word[`CTL_WRITE_FLAG] = access_write_flag;
        capture_word[`CTL_PERIPH_RESET] = peripheral_reset_request;
        capture_word[`CTL_RUN] = run_state;
        capture_word[`CTL_SYNC] = sync_hold & ~`TRACE_ABSENT;
    end

    // Trace mode is held only while the trace instruction stays loaded
    always @* begin
        if (debug_exc_i || ir != `IR_TRACE || `TRACE_ABSENT) begin
            next_trace_mode = 1'b0;
        end else if (tap_state == `TAP_RUN_IDLE) begin
            next_trace_mode = 1'b1;
        end else begin
            next_trace_mode = flow_trace_mode;
        end
    end

    // Instruction and data register paths, stepped by test clock edges
    always @(posedge clk_i) begin
        if (srst_i) begin
            ir <= `IR_BYPASS;
            ir_shift <= `IR_CAPTURE;
            dr <= `CTL_ZERO;
        end else if (debug_exc_i) begin
            ir <= `IR_BYPASS;
        end else if (tck_rise) begin
            case (tap_state)
                `TAP_RESET: ir <= `IR_BYPASS;
                `TAP_CAP_IR: ir_shift <= `IR_CAPTURE;
                `TAP_SHIFT_IR: ir_shift <= {tdi_s, ir_shift[`IR_WIDTH-1:1]};
                `TAP_UPD_IR: ir <= ir_shift;
                `TAP_CAP_DR: dr <= ctl_sel ? capture_word : `CTL_ZERO;
                `TAP_SHIFT_DR: begin
                    if (ctl_sel) begin
                        dr <= {tdi_s, dr[31:1]};
                    end else begin
                        dr <= {{31{1'b0}}, tdi_s};
                    end
                end
                default: dr <= dr;
            endcase
        end
    end

    // Processor access handshake and control bits on the bus clock
    always @(posedge clk_i) begin
        if (srst_i) begin
            processor_access_pending <= 1'b0;
            access_write_flag <= 1'b0;
            peripheral_reset_request <= 1'b0;
            probe_present <= 1'b0;
            sync_hold <= 1'b0;
            run_state <= `RUN_RESET;
            cpu_ack_o <= 1'b0;
            periph_reset_o <= 1'b0;
        end else begin
            run_state <= cpu_clk_running_i;
            // A clear wins; a new access in the same cycle is dropped, as set needs pending low
            processor_access_pending <= access_set
                | (processor_access_pending & ~access_clear);
            if (access_set) begin
                access_write_flag <= cpu_write_i;
            end
            if (ctl_update) begin
                peripheral_reset_request <= dr[`CTL_PERIPH_RESET];
                probe_present <= dr[`CTL_PROBE_PRESENT];
            end
            periph_reset_o <= peripheral_reset_request;
            if (sync_accept) begin
                sync_hold <= 1'b1;
            end else if (trace_entry || sync_zero) begin
                sync_hold <= 1'b0;
            end
            cpu_ack_o <= (access_clear & ~sync_accept)
                | (sync_hold & (trace_entry | sync_zero));
        end
    end

    // Trace clock divider and program counter serialiser
    always @(posedge clk_i) begin
        if (srst_i) begin
            div_cnt <= `DIV_ZERO;
            trace_clk_o <= 1'b0;
            pc_shift <= `CTL_ZERO;
            pc_left <= `PC_LEFT_ZERO;
            trace_bit <= 1'b0;
        end else begin
            // A high half runs to its end before the clock parks low
            if (!probe_present && !trace_clk_o) begin
                div_cnt <= `DIV_ZERO;
                trace_clk_o <= 1'b0;
            end else if (div_wrap) begin
                div_cnt <= `TRACE_CLK_HALF_CYC - `DIV_ONE;
                trace_clk_o <= ~trace_clk_o;
            end else begin
                div_cnt <= div_cnt - `DIV_ONE;
            end
            if (!flow_trace_mode) begin
                pc_left <= `PC_LEFT_ZERO;
                trace_bit <= 1'b0;
            end else if (pc_left == `PC_LEFT_ZERO && pc_valid_i) begin
                pc_shift <= pc_i;
                pc_left <= `PC_BITS;
            end else if (trace_fall && pc_left != `PC_LEFT_ZERO) begin
                trace_bit <= pc_shift[0];
                pc_shift <= {1'b0, pc_shift[31:1]};
                pc_left <= pc_left - `PC_LEFT_ONE;
            end else if (trace_fall) begin
                trace_bit <= 1'b0;
            end
        end
    end

    // Pin drivers and trace mode state
    always @(posedge clk_i) begin
        if (srst_i) begin
            flow_trace_mode <= 1'b0;
            trace_mode_o <= 1'b0;
            trace_status_o <= `STATUS_IDLE;
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else begin
            flow_trace_mode <= next_trace_mode;
            trace_mode_o <= flow_trace_mode;
            trace_status_o <= flow_trace_mode ? pc_status_i : `STATUS_IDLE;
            tdo_oe_o <= flow_trace_mode | (tap_state == `TAP_SHIFT_DR)
                | (tap_state == `TAP_SHIFT_IR);
            if (flow_trace_mode) begin
                tdo_o <= trace_bit;
            end else if (tck_fall && tap_state == `TAP_SHIFT_IR) begin
                tdo_o <= ir_shift[0];
            end else if (tck_fall && tap_state == `TAP_SHIFT_DR) begin
                tdo_o <= dr[0];
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/probe_ctrl_trace_monitor.sv
// Port checker for the probe control and flow trace block
`timescale 1ns/100ps
`default_nettype none
`include "probe_ctrl_defs.vh"
module probe_ctrl_trace_monitor (
    input wire clk_i,
    input wire srst_i,
    input wire tck_i,
    input wire tdo_oe_o,
    input wire trace_clk_o,
    input wire [2:0] trace_status_o,
    input wire cpu_req_i,
    input wire [31:0] cpu_addr_i,
    input wire cpu_ack_o,
    input wire debug_exc_i,
    input wire periph_reset_o,
    input wire trace_mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    reg req_open;
    reg tck_q;
    reg [4:0] quiet;
    always @(posedge clk_i) begin
        tck_q <= tck_i;
        if (srst_i) begin
            req_open <= 1'b0;
            quiet <= 5'h1F;
        end else begin
            if (cpu_ack_o)
                req_open <= 1'b0;
            if (cpu_req_i && cpu_addr_i >= `PROBE_ADDR_LO && cpu_addr_i <= `PROBE_ADDR_HI)
                req_open <= 1'b1;
            if (tck_i != tck_q)
                quiet <= 5'h00;
            else if (quiet != 5'h1F)
                quiet <= quiet + 5'h01;
        end
    end
    sequence s_leave;
        ##[1:2] !trace_mode_o;
    endsequence
    sequence s_hold;
        ##1 $stable(trace_clk_o);
    endsequence
    chk_ack_single: assert property (cpu_ack_o |=> !cpu_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (cpu_ack_o |-> req_open)
        else $error("ack without probe access");
    chk_status_zero: assert property (!trace_mode_o && !$past(trace_mode_o) |->
        trace_status_o == `STATUS_IDLE) else $error("status code outside trace");
    chk_exc_leave: assert property (debug_exc_i && trace_mode_o |-> s_leave)
        else $error("trace mode kept after exception");
    chk_oe_trace: assert property (trace_mode_o && $past(trace_mode_o) |-> tdo_oe_o)
        else $error("data out not driven in trace");
    chk_periph_tck: assert property ($changed(periph_reset_o) |-> quiet < 5'h10)
        else $error("peripheral reset moved without port access");
    chk_mode_tck: assert property ($rose(trace_mode_o) |-> quiet < 5'h10)
        else $error("trace mode entered without port access");
    chk_tclk_hold: assert property ($changed(trace_clk_o) |-> s_hold)
        else $error("trace clock half period too short");
endmodule
bind probe_ctrl_trace probe_ctrl_trace_monitor i_mon (.clk_i, .srst_i, .tck_i, .tdo_oe_o,
    .trace_clk_o, .trace_status_o, .cpu_req_i, .cpu_addr_i, .cpu_ack_o, .debug_exc_i,
    .periph_reset_o, .trace_mode_o);
`default_nettype wire

//--- tb/probe_model.sv
// Behavioural debug probe on the test port pins
`timescale 1ns/100ps
`default_nettype none
module probe_model (
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic tdo_i,
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o
);
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    // One test clock period; the clock rests low between frames
    task automatic step(input logic ms, input logic di, output logic to);
        @(negedge clk_i);
        tms_o = ms;
        tdi_o = di;
        repeat (slow_i ? 7 : 3) @(negedge clk_i);
        to = tdo_i;
        tck_o = 1'b1;
        repeat (4) @(negedge clk_i);
        tck_o = 1'b0;
    endtask
    // One register scan from idle back to idle, first bit lowest
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
            output logic [31:0] dout);
        logic t;
        dout = 32'h0000_0000;
        step(1'b1, 1'b0, t);
        if (ir)
            step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
        step(1'b0, 1'b0, t);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], t);
            dout[i] = t;
        end
        step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
        tdi_o = ~tdi_o;
    endtask
endmodule
`default_nettype wire

//--- tb/probe_ctrl_trace_tb_top.sv
// Self-checking bench for the probe control and flow trace block
`timescale 1ns/100ps
`default_nettype none
module probe_ctrl_trace_tb_top;
    logic clk_i, srst_i, tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, trace_clk_o, slow;
    logic cpu_req_i, cpu_write_i, cpu_ack_o, cpu_clk_running_i, debug_exc_i;
    logic pc_valid_i, periph_reset_o, trace_mode_o;
    logic [2:0] trace_status_o, pc_status_i;
    logic [31:0] cpu_addr_i, pc_i, r;
    logic [31:0] addrs [6] = '{32'hFF20_0000, 32'hFF2F_FFFF, 32'hFF20_0000, 32'hFF1F_FFFF,
        32'hFF30_0000, 32'hFF20_0200};
    int n_errors, checks, acks, exp_acks, pp, pend, wr, prst, sync, run;
    probe_ctrl_trace i_dut (.clk_i, .srst_i, .tck_i, .tms_i, .tdi_i, .tdo_o, .tdo_oe_o,
        .trace_clk_o, .trace_status_o, .cpu_req_i, .cpu_addr_i, .cpu_write_i, .cpu_ack_o,
        .cpu_clk_running_i, .debug_exc_i, .pc_valid_i, .pc_i, .pc_status_i, .periph_reset_o,
        .trace_mode_o);
    probe_model i_probe (.clk_i, .slow_i(slow), .tdo_i(tdo_o), .tck_o(tck_i), .tms_o(tms_i),
        .tdi_o(tdi_i));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(negedge clk_i) if (cpu_ack_o === 1'b1) acks++;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic ctl(input logic [31:0] w);
        logic [31:0] e;
        run = $urandom % 2;
        slow = $urandom % 2;
        cpu_clk_running_i = run[0];
        e = 32'(sync << 23 | run << 21 | prst << 20 | wr << 19 | pend << 18 | pp << 15);
        i_probe.scan(1'b0, 32, w, r);
        repeat (3) @(negedge clk_i);
        chk("control", r, e);
        pp = w[15];
        prst = w[20];
        if (pend && !w[18] && !wr && w[23])
            sync = 1;
        else if ((pend && !w[18]) || (sync && !w[23])) begin
            exp_acks++;
            sync = 0;
        end
        if (!w[18])
            pend = 0;
        chk("acks", acks, exp_acks);
        chk("periph reset", periph_reset_o, prst);
    endtask
    task automatic req(input logic [31:0] a, input logic w);
        @(negedge clk_i);
        cpu_req_i = 1'b1;
        cpu_addr_i = a;
        cpu_write_i = w;
        @(negedge clk_i);
        cpu_req_i = 1'b0;
        if (pp && !pend && !sync && a >= 32'hFF20_0000 && a <= 32'hFF2F_FFFF) begin
            pend = 1;
            wr = w;
        end
    endtask
    task automatic wait_mode(input logic v);
        for (int n = 0; n < 40 && trace_mode_o !== v; n++)
            @(negedge clk_i);
        chk("trace mode", trace_mode_o, v);
        if (trace_mode_o !== v)
            give_verdict();
    endtask
    task automatic tclk_up();
        logic prev;
        int n;
        n = 0;
        do begin
            prev = trace_clk_o;
            @(negedge clk_i);
            n++;
        end while (!(prev === 1'b0 && trace_clk_o === 1'b1) && n < 12);
        chk("trace clock", n < 12, 1'b1);
        if (n == 12)
            give_verdict();
    endtask
    initial begin
        srst_i = 1'b1;
        {cpu_req_i, cpu_write_i, debug_exc_i, pc_valid_i, slow} = 5'h00;
        {cpu_addr_i, pc_i, pc_status_i} = 67'h0;
        cpu_clk_running_i = 1'b1;
        void'($urandom(2044));
        r = $urandom;
        addrs[2] = {12'hFF2, r[19:0]};
        repeat (12) @(negedge clk_i);
        srst_i = 1'b0;
        i_probe.step(1'b0, 1'b0, r[0]);
        i_probe.scan(1'b1, 5, 32'h0000_000A, r);
        chk("ir capture", r, 32'h0000_0001);
        ctl(32'hFFFF_FFFF);
        ctl(32'h0000_8000);
        for (int k = 0; k < 6; k++) begin
            req(addrs[k], k[0]);
            req(addrs[k] ^ 32'h0000_0004, !k[0]);
            ctl({8'h00, k[0], 7'h00, 1'b1, 15'h0000});
        end
        req(32'hFF20_0200, 1'b0);
        ctl(32'h0080_8000);
        ctl(32'h0000_8000);
        req(32'hFF20_0200, 1'b0);
        ctl(32'h0080_8000);
        i_probe.scan(1'b1, 5, 32'h0000_0010, r);
        wait_mode(1'b1);
        exp_acks++;
        sync = 0;
        chk("data out enable", tdo_oe_o, 1'b1);
        pc_status_i = $urandom;
        tclk_up();
        pc_i = $urandom;
        pc_valid_i = 1'b1;
        @(negedge clk_i);
        pc_valid_i = 1'b0;
        for (int i = 0; i < 32; i++) begin
            tclk_up();
            r[i] = tdo_o;
        end
        chk("trace pc", r, pc_i);
        chk("trace status", trace_status_o, pc_status_i);
        chk("acks", acks, exp_acks);
        debug_exc_i = 1'b1;
        @(negedge clk_i);
        debug_exc_i = 1'b0;
        wait_mode(1'b0);
        i_probe.scan(1'b0, 2, 32'h0000_0003, r);
        chk("bypass path", r, 32'h0000_0002);
        i_probe.scan(1'b1, 5, 32'h0000_000A, r);
        ctl(32'h0000_0000);
        repeat (20) begin
            @(negedge clk_i);
            chk("trace clock idle", trace_clk_o, 1'b0);
        end
        req(32'hFF20_0000, 1'b1);
        ctl(32'h0000_0000);
        give_verdict();
    end
endmodule
`default_nettype wire
